// ==== clock_control_defs.vh ====
// Constants of the sub-CPU and system clock control block.
// Assumes byte-wide registers on a 16-bit register address space.
`ifndef CLOCK_CONTROL_DEFS_VH
`define CLOCK_CONTROL_DEFS_VH

// Register addresses
`define ADDR_SUBCPU_CLOCK_CONFIG    16'hFF73
`define ADDR_PLL_MULTIPLIER_CONTROL 16'hFF9E
`define ADDR_SYSTEM_CLOCK_CONTROL   16'hFF9F

// Reset values
`define RST_SUBCPU_CLOCK_CONFIG     8'h00
`define RST_PLL_MULTIPLIER_CONTROL  8'h00
`define RST_SYSTEM_CLOCK_CONTROL    8'h02

// Sub-CPU clock configuration fields
`define CFG_DEBUG_BIT               0
`define CFG_DIV_LSB                 1
`define CFG_DIV_MSB                 3
`define CFG_WAIT_LSB                4
`define CFG_WAIT_MSB                6
`define CFG_MODSEL_BIT              7

// Divider codes
`define DIV_BY_1                    3'h0
`define DIV_BY_1P5                  3'h1
`define DIV_BY_2                    3'h2
`define DIV_BY_3                    3'h3
`define DIV_BY_4                    3'h4

// Multiplier control fields
`define MUL_CODE_LSB                0
`define MUL_CODE_MSB                6
`define MUL_MODE_BIT                7

// System clock control fields
`define CLK_XTAL_LSB                0
`define CLK_XTAL_MSB                1
`define CLK_SRC_BIT                 6
`define CLK_PWR_BIT                 7
`define SYSTEM_CLOCK_CONTROL_MASK                8'hC3

// Crystal range predivider ratios
`define XTAL_DIV_00                 7'h10
`define XTAL_DIV_01                 7'h16
`define XTAL_DIV_10                 7'h20
`define XTAL_DIV_11                 7'h40

// Multiplier post-divide ratios
`define POST_DIV_MODE0              3'h4
`define POST_DIV_MODE1              3'h2

// Multiplier code lookup: code sequence start, frequency range in MHz
`define MUL_SEQ_START               7'h02
`define MUL_FREQ_FIRST              8'h03
`define MUL_FREQ_LAST               8'h80

`endif

// ==== subcpu_pulse_gen.v ====
// Sub-CPU clock pulse generator with wait-state insertion.
// Assumes settings are static register values; access is synchronous.
`include "clock_control_defs.vh"

module subcpu_pulse_gen (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire [2:0] div_code,
  input  wire [2:0] wait_code,
  input  wire       subcpu_access,
  output reg        subcpu_clk_pulse_r,
  output reg        subcpu_clk_half_r,
  output reg        subcpu_wait_r
);

  reg [2:0] cur_div_r;
  reg [2:0] cur_wait_r;
  reg [1:0] ph_r;
  reg [2:0] wait_cnt_r;
  reg [1:0] last_ph;
  reg       slot;
  reg       frame_end;

  always @* begin
    case (cur_div_r)
      `DIV_BY_1:   last_ph = 2'h0;
      `DIV_BY_1P5: last_ph = 2'h2;
      `DIV_BY_2:   last_ph = 2'h1;
      `DIV_BY_3:   last_ph = 2'h2;
      default:     last_ph = 2'h3;
    endcase
    // 1.5 gives two pulses in every three cycles; others one per frame
    if (cur_div_r == `DIV_BY_1P5)
      slot = (ph_r != 2'h2);
    else
      slot = (ph_r == 2'h0);
    frame_end = (ph_r == last_ph);
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      cur_div_r          <= `DIV_BY_1;
      cur_wait_r         <= 3'h0;
      ph_r               <= 2'h0;
      wait_cnt_r         <= 3'h0;
      subcpu_clk_pulse_r <= 1'b0;
      subcpu_clk_half_r  <= 1'b1;
      subcpu_wait_r      <= 1'b0;
    end else begin
      // Phase counter never restarts on waits, so the pulse grid stays fixed
      ph_r <= frame_end ? 2'h0 : ph_r + 2'h1;
      if (frame_end) begin
        // Settings switch only between frames: no cut pulse
        cur_div_r  <= (div_code > `DIV_BY_4) ? `DIV_BY_4 : div_code;
        cur_wait_r <= wait_code;
      end
      if (slot && wait_cnt_r != 3'h0) begin
        // Swallow whole pulse slots instead of stretching a pulse
        subcpu_clk_pulse_r <= 1'b0;
        wait_cnt_r         <= wait_cnt_r - 3'h1;
        subcpu_wait_r      <= (wait_cnt_r != 3'h1);
      end else begin
        subcpu_clk_pulse_r <= slot;
        if (slot && subcpu_access && cur_wait_r != 3'h0) begin
          wait_cnt_r    <= cur_wait_r;
          subcpu_wait_r <= 1'b1;
        end
      end
      // Pulse is gated by the high phase of core_clk for 1 and 1.5
      subcpu_clk_half_r <= (cur_div_r == `DIV_BY_1) || (cur_div_r == `DIV_BY_1P5);
      if (cur_div_r > `DIV_BY_1P5)
        subcpu_clk_half_r <= 1'b0;
    end
  end

endmodule

// ==== clock_control.v ====
// Clock generation control: sub-CPU clock, wait states, PLL settings.
// Assumes a byte register port synchronous to core_clk; buffer RAM and
// PLL analog parts sit outside and take the settings from the outputs.
//
// Strobed register access was left to the implementer.
`include "clock_control_defs.vh"

// Notes on behaviour
// - Sub-CPU accesses get 0 to 7 wait states from the three-bit wait field.
// - Sub-CPU clock is system clock divided by 1, 1.5, 2, 3 or 4 for codes 0 to 4.
// - With the debug bit set, every register write is also copied to buffer RAM.
// - At divide by 1 and 1.5 the sub-CPU pulse lasts the high phase of sysclk.
// - At divide by 2, 3 and 4 the sub-CPU pulse lasts one sysclk period.
// - The sub-CPU clock keeps low jitter while wait states are inserted.
// - PLL power bit powers the PLL when one; source bit picks the multiplier when one.
// - Crystal range field picks a reference predivider of 16, 22, 32 or 64.
// - Mode bit divides the oscillator by four when zero and by two when one.
// - The seven-bit multiplier code maps to 3 to 128 MHz through a fixed lookup; codes 0x00 and 0x01 give 0.
module clock_control (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_r,
  input  wire        subcpu_access,
  output wire        subcpu_clk_pulse_r,
  output wire        subcpu_clk_half_r,
  output wire        subcpu_wait_r,
  output reg         shadow_wr_r,
  output reg  [15:0] shadow_addr_r,
  output reg  [7:0]  shadow_data_r,
  output reg         pll_power_r,
  output reg         sysclk_src_sel_r,
  output reg  [6:0]  pll_prediv_r,
  output reg  [2:0]  post_div_r,
  output reg  [7:0]  vco_freq_mhz_r,
  output reg         vco_freq_valid_r
);

  reg  [7:0] subcpu_clock_config_r;
  reg  [7:0] pll_multiplier_control_r;
  reg  [7:0] system_clock_control_r;
  reg  [6:0] seq_r;
  reg  [7:0] seq_freq_r;
  reg        search_r;
  reg  [7:0] rdata_nxt;
  reg  [6:0] prediv_nxt;
  wire       wr_cfg;
  wire       wr_mul;
  wire       wr_clk;
  wire [6:0] mul_code;

  assign wr_cfg   = reg_wr && (reg_addr == `ADDR_SUBCPU_CLOCK_CONFIG);
  assign wr_mul   = reg_wr && (reg_addr == `ADDR_PLL_MULTIPLIER_CONTROL);
  assign wr_clk   = reg_wr && (reg_addr == `ADDR_SYSTEM_CLOCK_CONTROL);
  assign mul_code = pll_multiplier_control_r[`MUL_CODE_MSB:`MUL_CODE_LSB];

  // Register file
  always @(posedge core_clk) begin
    if (!nrst) begin
      subcpu_clock_config_r    <= `RST_SUBCPU_CLOCK_CONFIG;
      pll_multiplier_control_r <= `RST_PLL_MULTIPLIER_CONTROL;
      system_clock_control_r   <= `RST_SYSTEM_CLOCK_CONTROL;
    end else begin
      if (wr_cfg)
        subcpu_clock_config_r <= reg_wdata;
      if (wr_mul)
        pll_multiplier_control_r <= reg_wdata;
      // Source bit is stored plainly; later writes are software's concern
      if (wr_clk)
        system_clock_control_r <= reg_wdata & `SYSTEM_CLOCK_CONTROL_MASK;
    end
  end

  always @* begin
    case (reg_addr)
      `ADDR_SUBCPU_CLOCK_CONFIG:    rdata_nxt = subcpu_clock_config_r;
      `ADDR_PLL_MULTIPLIER_CONTROL: rdata_nxt = pll_multiplier_control_r;
      `ADDR_SYSTEM_CLOCK_CONTROL:   rdata_nxt = system_clock_control_r;
      default:                      rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (!nrst)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= 8'h00;
  end

  // Debug shadow of writes; the bit as it stood before the write decides
  always @(posedge core_clk) begin
    if (!nrst) begin
      shadow_wr_r   <= 1'b0;
      shadow_addr_r <= 16'h0000;
      shadow_data_r <= 8'h00;
    end else begin
      shadow_wr_r <= reg_wr && subcpu_clock_config_r[`CFG_DEBUG_BIT];
      if (reg_wr) begin
        shadow_addr_r <= reg_addr;
        shadow_data_r <= reg_wdata;
      end
    end
  end

  subcpu_pulse_gen u_pulse_gen (
    .core_clk           (core_clk),
    .nrst               (nrst),
    .div_code           (subcpu_clock_config_r[`CFG_DIV_MSB:`CFG_DIV_LSB]),
    .wait_code          (subcpu_clock_config_r[`CFG_WAIT_MSB:`CFG_WAIT_LSB]),
    .subcpu_access      (subcpu_access),
    .subcpu_clk_pulse_r (subcpu_clk_pulse_r),
    .subcpu_clk_half_r  (subcpu_clk_half_r),
    .subcpu_wait_r      (subcpu_wait_r)
  );

  // PLL and system clock settings
  always @* begin
    case (system_clock_control_r[`CLK_XTAL_MSB:`CLK_XTAL_LSB])
      2'h0:    prediv_nxt = `XTAL_DIV_00;
      2'h1:    prediv_nxt = `XTAL_DIV_01;
      2'h2:    prediv_nxt = `XTAL_DIV_10;
      default: prediv_nxt = `XTAL_DIV_11;
    endcase
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      pll_power_r      <= 1'b0;
      sysclk_src_sel_r <= 1'b0;
      pll_prediv_r     <= `XTAL_DIV_10;
      post_div_r       <= `POST_DIV_MODE0;
    end else begin
      pll_power_r      <= system_clock_control_r[`CLK_PWR_BIT];
      sysclk_src_sel_r <= system_clock_control_r[`CLK_SRC_BIT];
      pll_prediv_r     <= prediv_nxt;
      post_div_r       <= pll_multiplier_control_r[`MUL_MODE_BIT] ?
                          `POST_DIV_MODE1 : `POST_DIV_MODE0;
    end
  end

  // Code lookup: the table follows a 7-bit shift sequence, one MHz a step,
  // so it is walked after each write instead of stored as 126 entries.
  always @(posedge core_clk) begin
    if (!nrst) begin
      seq_r            <= `MUL_SEQ_START;
      seq_freq_r       <= `MUL_FREQ_FIRST;
      search_r         <= 1'b0;
      vco_freq_mhz_r   <= 8'h00;
      vco_freq_valid_r <= 1'b1;
    end else if (wr_mul) begin
      seq_r            <= `MUL_SEQ_START;
      seq_freq_r       <= `MUL_FREQ_FIRST;
      search_r         <= 1'b1;
      vco_freq_valid_r <= 1'b0;
    end else if (search_r) begin
      if (seq_r == mul_code) begin
        vco_freq_mhz_r   <= seq_freq_r;
        search_r         <= 1'b0;
        vco_freq_valid_r <= 1'b1;
      end else if (seq_freq_r == `MUL_FREQ_LAST) begin
        vco_freq_mhz_r   <= 8'h00;
        search_r         <= 1'b0;
        vco_freq_valid_r <= 1'b1;
      end else begin
        seq_r      <= {seq_r[5:0], seq_r[6] ^ seq_r[3]};
        seq_freq_r <= seq_freq_r + 8'h01;
      end
    end
  end

endmodule

// ==== clock_control_sva.sv ====
// Port checker for the clock control block.
// Assumes a bind into clock_control; one clock domain.
module clock_control_sva (
  input wire        core_clk,
  input wire        nrst,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        subcpu_clk_pulse_r,
  input wire        subcpu_wait_r,
  input wire        shadow_wr_r,
  input wire        pll_power_r,
  input wire        sysclk_src_sel_r,
  input wire [6:0]  pll_prediv_r,
  input wire [2:0]  post_div_r,
  input wire [7:0]  vco_freq_mhz_r,
  input wire        vco_freq_valid_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  function automatic [6:0] pd(input [7:0] x);
    pd = x[1:0] == 2'h0 ? 7'h10 : x[1:0] == 2'h1 ? 7'h16 : x[1:0] == 2'h2 ? 7'h20 : 7'h40;
  endfunction
  sequence clk_wr_s;
    reg_wr && reg_addr == 16'hFF9F;
  endsequence
  sequence lookup_done_s;
    ##[1:127] vco_freq_valid_r;
  endsequence
  chk_shadow_cause: assert property (shadow_wr_r |-> $past(reg_wr))
    else $error("shadow write without a register write");
  chk_power_bit: assert property (clk_wr_s |-> ##2 pll_power_r == $past(reg_wdata[7], 2))
    else $error("power bit not applied");
  chk_src_bit: assert property (clk_wr_s |-> ##2 sysclk_src_sel_r == $past(reg_wdata[6], 2))
    else $error("source bit not applied");
  chk_prediv_map: assert property (clk_wr_s |-> ##2 pll_prediv_r == pd($past(reg_wdata, 2)))
    else $error("predivider ratio wrong");
  chk_post_div: assert property (reg_wr && reg_addr == 16'hFF9E |->
    ##2 post_div_r == ($past(reg_wdata[7], 2) ? 3'h2 : 3'h4))
    else $error("post divide ratio wrong");
  chk_lookup_bound: assert property ($fell(vco_freq_valid_r) |-> lookup_done_s)
    else $error("lookup did not finish in time");
  chk_freq_range: assert property (vco_freq_valid_r && vco_freq_mhz_r != 8'h00 |->
    vco_freq_mhz_r >= 8'h03 && vco_freq_mhz_r <= 8'h80)
    else $error("looked-up frequency out of range");
  chk_wait_gap: assert property (subcpu_wait_r && $past(subcpu_wait_r) |-> !subcpu_clk_pulse_r)
    else $error("pulse issued during wait slots");
  chk_wait_entry: assert property ($rose(subcpu_wait_r) |-> subcpu_clk_pulse_r)
    else $error("wait started without the access pulse");
endmodule
bind clock_control clock_control_sva chk (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .subcpu_clk_pulse_r, .subcpu_wait_r, .shadow_wr_r, .pll_power_r, .sysclk_src_sel_r,
  .pll_prediv_r, .post_div_r, .vco_freq_mhz_r, .vco_freq_valid_r);

// ==== subcpu_core_model.sv ====
// Sub-CPU stand-in: requests wait-stated accesses and counts clock pulses.
// Assumes the pulse output of the clock control block on the same clock.
module subcpu_core_model (
  input  wire    core_clk,
  input  wire    nrst,
  input  wire    access_en,
  input  wire    subcpu_clk_pulse_r,
  output logic   subcpu_access,
  output integer n_pulse
);
  // Access stays a level, the core only advances on pulses
  always @(posedge core_clk) begin
    if (!nrst) begin
      subcpu_access <= 1'b0;
      n_pulse <= 0;
    end else begin
      subcpu_access <= access_en;
      if (subcpu_clk_pulse_r === 1'b1) n_pulse <= n_pulse + 1;
    end
  end
endmodule

// ==== tb_clock_control.sv ====
// Self-checking bench for the clock control block.
// Assumes the sub-CPU model drives the access line.
module tb_clock_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, acc_en = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, rd_val;
  wire         subcpu_access, pulse, half, wait_q, sh_wr, pwr, src, valid;
  wire  [15:0] sh_addr;
  wire  [7:0]  rdata, sh_data, freq;
  wire  [6:0]  prediv;
  wire  [2:0]  post_div;
  integer      n_pulse, n_mismatch = 0, n_tests = 0, cyc = 0, p0;
  clock_control dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r(rdata), .subcpu_access, .subcpu_clk_pulse_r(pulse), .subcpu_clk_half_r(half),
    .subcpu_wait_r(wait_q), .shadow_wr_r(sh_wr), .shadow_addr_r(sh_addr),
    .shadow_data_r(sh_data), .pll_power_r(pwr), .sysclk_src_sel_r(src), .pll_prediv_r(prediv),
    .post_div_r(post_div), .vco_freq_mhz_r(freq), .vco_freq_valid_r(valid));
  subcpu_core_model core (.core_clk, .nrst, .access_en(acc_en), .subcpu_clk_pulse_r(pulse),
    .subcpu_access, .n_pulse);
  initial forever #25 core_clk = ~core_clk;
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask
  task automatic t_regs;
    rd(16'hFF73);
    cmp("cfg reset", 16'h0000, rd_val);
    rd(16'hFF9F);
    cmp("clk reset", 16'h0002, rd_val);
    @(posedge core_clk);
    #1;
    cmp("rdata idle", 16'h0000, rdata);
    rd(16'h1234);
    cmp("unmapped", 16'h0000, rd_val);
    cmp("power reset", 16'h0000, pwr);
    cmp("post reset", 16'h0004, post_div);
  endtask
  task automatic t_system_clock_control;
    logic [6:0] pd [4] = '{7'h10, 7'h16, 7'h20, 7'h40};
    for (int x = 0; x < 4; x++) begin
      // Source bit goes to one only on the last pass, never back to zero
      wr(16'hFF9F, {x[0], x == 3, 4'hF, x[1:0]});
      repeat (2) @(posedge core_clk);
      #1;
      cmp("power", x[0], pwr);
      cmp("source", x == 3, src);
      cmp("prediv", pd[x], prediv);
      rd(16'hFF9F);
      cmp("clk readback", {x[0], x == 3, 4'h0, x[1:0]}, rd_val);
    end
  endtask
  task automatic t_mult;
    logic [6:0] code [4] = '{7'h02, 7'h41, 7'h47, 7'h00};
    logic [7:0] mhz [4] = '{8'h03, 8'h20, 8'h5E, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(16'hFF9E, {i[0], code[i]});
      cmp("valid low", 16'h0000, valid);
      repeat (2) @(posedge core_clk);
      for (int k = 0; k < 130 && valid !== 1'b1; k++) @(posedge core_clk);
      #1;
      cmp("valid", 16'h0001, valid);
      cmp("frequency", mhz[i], freq);
      cmp("post divide", i[0] ? 16'h0002 : 16'h0004, post_div);
    end
  endtask
  task automatic t_debug;
    wr(16'hFF73, 8'h01);
    cmp("shadow off", 16'h0000, sh_wr);
    wr(16'h0100, 8'hA5);
    cmp("shadow on", 16'h0001, sh_wr);
    cmp("shadow addr", 16'h0100, sh_addr);
    cmp("shadow data", 16'h00A5, sh_data);
    wr(16'hFF73, 8'h00);
  endtask
  task automatic t_div;
    int exp [6] = '{12, 8, 6, 4, 3, 3};
    for (int c = 0; c < 6; c++) begin
      wr(16'hFF73, {4'h0, c[2:0], 1'b0});
      repeat (12) @(posedge core_clk);
      p0 = n_pulse;
      repeat (12) @(posedge core_clk);
      cmp("pulses", exp[c], n_pulse - p0);
      cmp("half flag", c < 2, half);
    end
  endtask
  task automatic t_wait;
    int ws [5] = '{0, 1, 2, 3, 5};
    logic seen;
    acc_en <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(16'hFF73, {1'b0, ws[i][2:0], 3'h2, 1'b0});
      repeat (16) @(posedge core_clk);
      p0 = n_pulse;
      seen = 1'b0;
      repeat (24) begin
        @(posedge core_clk);
        if (wait_q === 1'b1) seen = 1'b1;
      end
      cmp("waited pulses", 12 / (ws[i] + 1), n_pulse - p0);
      cmp("wait seen", ws[i] > 0, seen);
    end
    acc_en <= 1'b0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Generous ceiling, a full run takes near 700 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_system_clock_control();
    t_mult();
    t_debug();
    t_div();
    t_wait();
    finish_test();
  end
endmodule
